// >>> hdl/bus_pkg.sv
package bus_pkg;
  // bus widths and control line positions (all lines active low)
  localparam int ADDR_W      = 22;
  localparam int DATA_W      = 16;
  localparam int CTL_W       = 18;
  localparam int PAR_ERR_BIT = 16;
  localparam int PAR_EN_BIT  = 17;
  localparam int LN_CYCLE    = 0;
  localparam int LN_DIN      = 1;
  localparam int LN_DOUT     = 2;
  localparam int LN_REPLY    = 3;
  localparam int LN_WR_BYTE  = 4;
  localparam int LN_IO_PAGE  = 5;
  localparam int LN_HALT     = 6;
  localparam int LN_REFRESH  = 7;
  localparam int LN_EVENT    = 8;
  localparam int LN_INIT     = 9;
  localparam int LN_DC_OK    = 10;
  localparam int LN_AC_OK    = 11;
  localparam int LN_DMA_REQ  = 12;
  localparam int LN_DMA_ACK  = 13;
  localparam int LN_IRQ_BASE = 14;
  localparam int IRQ_LVLS    = 4;

  // timing, in ns and in 4 ns clock cycles
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TIMEOUT_NS     = 10000;
  localparam int ADDR_SETUP_NS  = 20;
  localparam int ADDR_HOLD_NS   = 20;
  localparam int DATA_SETUP_NS  = 20;
  localparam int INIT_NS        = 1000;
  localparam int REPLY_NS       = 40;
  localparam int MAX_REPLY_NS   = 2000;

  function automatic int ns_up(input int ns);
    ns_up = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (ns_up < 1)
    begin
      ns_up = 1;
    end
  endfunction : ns_up

  localparam int TIMEOUT_CYCLES   = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int ADDR_SETUP_CYC   = ns_up(ADDR_SETUP_NS);
  localparam int ADDR_HOLD_CYC    = ns_up(ADDR_HOLD_NS);
  localparam int DATA_SETUP_CYC   = ns_up(DATA_SETUP_NS);
  localparam int INIT_CYC         = ns_up(INIT_NS);
  localparam int REPLY_CYC        = ns_up(REPLY_NS);
  localparam int MAX_REPLY_CYC    = ns_up(MAX_REPLY_NS);
  localparam int DLY_W            = 8;
  localparam int INIT_W           = $clog2(INIT_CYC + 1);
  localparam int SYNC_MARGIN_CYC  = 4;
endpackage : bus_pkg

// >>> hdl/backplane_if.sv
`timescale 1ns/1ps
// one processor end and one device end on a terminated backplane
interface backplane_if;
  import bus_pkg::*;
  logic [ADDR_W-1:0] dal_n;
  logic [CTL_W-1:0]  ctl_n;
  logic [ADDR_W-1:0] m_dal_n;
  logic [ADDR_W-1:0] m_dal_oe;
  logic [CTL_W-1:0]  m_ctl_n;
  logic [CTL_W-1:0]  m_ctl_oe;
  logic [ADDR_W-1:0] s_dal_n;
  logic [ADDR_W-1:0] s_dal_oe;
  logic [CTL_W-1:0]  s_ctl_n;
  logic [CTL_W-1:0]  s_ctl_oe;
  logic              iak_n;
  logic              dmg_n;

  // wired-and: a driven low wins, termination gives high
  assign dal_n = ~((m_dal_oe & ~m_dal_n) | (s_dal_oe & ~s_dal_n));
  assign ctl_n = ~((m_ctl_oe & ~m_ctl_n) | (s_ctl_oe & ~s_ctl_n));

  modport master (
    input  dal_n, ctl_n,
    output m_dal_n, m_dal_oe, m_ctl_n, m_ctl_oe, iak_n, dmg_n
  );
  modport slave (
    input  dal_n, ctl_n, iak_n, dmg_n,
    output s_dal_n, s_dal_oe, s_ctl_n, s_ctl_oe
  );
endinterface : backplane_if

// >>> hdl/sync_2ff.sv
`timescale 1ns/1ps
// two-stage synchronizer for asynchronous bus lines
module sync_2ff #(
  parameter int              WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
)(
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_r <= RESET_VAL;
      q_o    <= RESET_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : sync_2ff

// >>> hdl/bus_master_end.sv
`timescale 1ns/1ps
// Overview of operation
// - bus has 40 two-way, 2 one-way lines
// - lines 15..0 carry address then data
// - lines 17..16 carry address then parity
// - lines 21..18 carry extended address only
// - every module decodes full 22-bit address
// - control lines: transfer, system, interrupt/DMA
// - assert by pulling low, release for high
// - processor heads acknowledge and grant chains
// - devices pass chain on when not requesting
// - only one bus master at a time
// - processor arbitrates bus mastership
// - addressed slave acknowledges and moves data
// - master waits for slave response
// - handshake steps follow partner edges only
// - abort cycle, flag error after 10 us
// - timeout longer than slowest slave reply
// - cycle line held through whole transaction; not driven for vector fetch
// - slave answers strobes with reply line
// - block mode: one address, consecutive words
// - data phase: 16 parity error, 17 enable
module bus_master_end
  import bus_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES,
  parameter int SLOWEST_CYC = MAX_REPLY_CYC
)(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic              req_byte_i,
  input  wire logic              req_io_i,
  input  wire logic              req_more_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic              iack_req_i,
  input  wire logic              init_req_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic      [DATA_W-1:0] rsp_rdata_o,
  output logic                   rsp_timeout_o,
  output logic                   rsp_parity_err_o,
  output logic    [IRQ_LVLS-1:0] irq_pending_o,
  output logic                   dma_granted_o,
  output logic                   sys_halt_o,
  output logic                   sys_event_o,
  output logic                   power_ok_o,
  backplane_if.master            bus
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  // timeout must outlast the slowest slave plus synchronizer lag
  if (TIMEOUT_CYC <= SLOWEST_CYC + SYNC_MARGIN_CYC)
  begin : g_bad_timeout
    $error("timeout shorter than slowest slave reply");
  end
  if (ADDR_SETUP_CYC > 255 || DATA_SETUP_CYC > 255)
  begin : g_bad_dly
    $error("setup delay does not fit its counter");
  end

  typedef enum logic [3:0] {
    M_IDLE    = 4'h0,
    M_ADDR    = 4'h1,
    M_SYNC    = 4'h2,
    M_STROBE  = 4'h3,
    M_WAIT    = 4'h4,
    M_RLS     = 4'h5,
    M_NEXT    = 4'h6,
    M_DMA_GNT = 4'h7,
    M_DMA_OWN = 4'h8
  } mst_state_type;

  typedef struct packed {
    mst_state_type       st;
    logic [ADDR_W-1:0]   dal_oe;
    logic [CTL_W-1:0]    ctl_oe;
    logic                iak_n;
    logic                dmg_n;
    logic [TW-1:0]       tmo;
    logic [DLY_W-1:0]    dly;
    logic [INIT_W-1:0]   init_cnt;
    logic                is_write;
    logic                is_byte;
    logic                is_iack;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic                req_ready;
    logic                rsp_valid;
    logic                rsp_timeout;
    logic                rsp_par;
    logic                dma_granted;
    logic [IRQ_LVLS-1:0] irq;
    logic                halt;
    logic                evnt;
    logic                pok;
  } mst_reg_type;

  mst_reg_type             r;
  mst_reg_type             n;
  logic [ADDR_W+CTL_W-1:0] in_n;
  logic [ADDR_W-1:0]       dal_a;
  logic [CTL_W-1:0]        ctl_a;

  // all partner lines cross into the clock domain here
  sync_2ff #(
    .WIDTH     (ADDR_W + CTL_W),
    .RESET_VAL ('1)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     ({bus.ctl_n, bus.dal_n}),
    .q_o     (in_n)
  );
  assign dal_a = ~in_n[ADDR_W-1:0];
  assign ctl_a = ~in_n[ADDR_W+CTL_W-1:ADDR_W];

  // next-state logic of the master and arbiter
  always_comb
  begin
    n             = r;
    n.rsp_valid   = 1'b0;
    n.rsp_timeout = 1'b0;
    n.irq         = ctl_a[LN_IRQ_BASE +: IRQ_LVLS];
    n.halt        = ctl_a[LN_HALT];
    n.evnt        = ctl_a[LN_EVENT];
    n.pok         = ctl_a[LN_DC_OK] & ctl_a[LN_AC_OK];
    if (r.init_cnt != '0)
    begin
      n.init_cnt = r.init_cnt - 1'b1;
    end
    if (init_req_i)
    begin
      n.init_cnt = INIT_W'(INIT_CYC);
    end
    if (r.dly != '0)
    begin
      n.dly = r.dly - 1'b1;
    end
    // counter restarts when the data phase begins and runs until reply is seen
    if (r.st inside {M_ADDR, M_SYNC, M_STROBE, M_WAIT})
    begin
      n.tmo = r.tmo + 1'b1;
    end
    case (r.st)
      M_IDLE:
      begin
        if (r.req_ready && iack_req_i)
        begin
          n.is_iack            = 1'b1;
          n.ctl_oe[LN_DIN]     = 1'b1;
          n.dly                = DLY_W'(DATA_SETUP_CYC - 1);
          n.tmo                = '0;
          n.st                 = M_STROBE;
        end
        else if (r.req_ready && req_valid_i)
        begin
          // full address out, bits 21..16 included
          n.dal_oe             = req_addr_i;
          n.ctl_oe[LN_IO_PAGE] = req_io_i;
          n.ctl_oe[LN_WR_BYTE] = req_write_i;
          n.is_write           = req_write_i;
          n.is_byte            = req_byte_i;
          n.wdata              = req_wdata_i;
          n.dly                = DLY_W'(ADDR_SETUP_CYC - 1);
          n.tmo                = '0;
          n.st                 = M_ADDR;
        end
        else if (r.req_ready && ctl_a[LN_DMA_REQ])
        begin
          // grant only while the processor owns no cycle
          n.dmg_n              = 1'b0;
          n.st                 = M_DMA_GNT;
        end
      end
      M_ADDR:
      begin
        if (r.dly == '0)
        begin
          n.ctl_oe[LN_CYCLE] = 1'b1;
          n.dly              = DLY_W'(ADDR_HOLD_CYC - 1);
          n.st               = M_SYNC;
        end
      end
      M_SYNC:
      begin
        if (r.dly == '0)
        begin
          // lines turn from address to data
          n.dal_oe             = r.is_write ? ADDR_W'(r.wdata) : '0;
          n.ctl_oe[LN_IO_PAGE] = 1'b0;
          n.ctl_oe[LN_WR_BYTE] = r.is_write & r.is_byte;
          n.dly                = DLY_W'(DATA_SETUP_CYC - 1);
          n.tmo                = '0;
          n.st                 = M_STROBE;
        end
      end
      M_STROBE:
      begin
        if (r.dly == '0)
        begin
          if (r.is_iack)
          begin
            n.iak_n = 1'b0;
          end
          else if (r.is_write)
          begin
            n.ctl_oe[LN_DOUT] = 1'b1;
          end
          else
          begin
            n.ctl_oe[LN_DIN] = 1'b1;
          end
          n.st = M_WAIT;
        end
      end
      M_WAIT:
      begin
        // nothing completes without the slave's reply
        if (ctl_a[LN_REPLY])
        begin
          n.rdata           = dal_a[DATA_W-1:0];
          n.rsp_par         = dal_a[PAR_ERR_BIT] & dal_a[PAR_EN_BIT];
          n.ctl_oe[LN_DIN]  = 1'b0;
          n.ctl_oe[LN_DOUT] = 1'b0;
          n.iak_n           = 1'b1;
          n.st              = M_RLS;
        end
        else if (r.tmo >= TW'(TIMEOUT_CYC - 1))
        begin
          // no answer: drop every line and flag the error
          n.dal_oe      = '0;
          n.ctl_oe      = '0;
          n.iak_n       = 1'b1;
          n.is_iack     = 1'b0;
          n.rsp_timeout = 1'b1;
          n.st          = M_IDLE;
        end
      end
      M_RLS:
      begin
        if (!ctl_a[LN_REPLY])
        begin
          n.rsp_valid = 1'b1;
          n.dal_oe    = '0;
          n.st        = M_NEXT;
        end
      end
      M_NEXT:
      begin
        if (req_more_i && !r.is_iack)
        begin
          // next word of a block, address stays with the slave
          n.dal_oe             = r.is_write ? ADDR_W'(req_wdata_i) : '0;
          n.ctl_oe[LN_WR_BYTE] = 1'b0;
          n.dly                = DLY_W'(DATA_SETUP_CYC - 1);
          n.tmo                = '0;
          n.st                 = M_STROBE;
        end
        else
        begin
          n.ctl_oe[LN_CYCLE]   = 1'b0;
          n.ctl_oe[LN_WR_BYTE] = 1'b0;
          n.ctl_oe[LN_DIN]     = 1'b0;
          n.is_iack            = 1'b0;
          n.st                 = M_IDLE;
        end
      end
      M_DMA_GNT:
      begin
        if (ctl_a[LN_DMA_ACK])
        begin
          n.dmg_n       = 1'b1;
          n.dma_granted = 1'b1;
          n.st          = M_DMA_OWN;
        end
        else if (!ctl_a[LN_DMA_REQ])
        begin
          n.dmg_n = 1'b1;
          n.st    = M_IDLE;
        end
      end
      M_DMA_OWN:
      begin
        // device is master until it lets go of ack and cycle
        if (!ctl_a[LN_DMA_ACK] && !ctl_a[LN_CYCLE])
        begin
          n.dma_granted = 1'b0;
          n.st          = M_IDLE;
        end
      end
      default:
      begin
        n.st = M_IDLE;
      end
    endcase
    n.ctl_oe[LN_INIT] = (n.init_cnt != '0);
    n.req_ready = (n.st == M_IDLE) && (n.init_cnt == '0);
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      r                 <= '0;
      r.iak_n           <= 1'b1;
      r.dmg_n           <= 1'b1;
      r.init_cnt        <= INIT_W'(INIT_CYC);
      r.ctl_oe[LN_INIT] <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // open-collector drive: value low, enable asserts
  assign bus.m_dal_n      = '0;
  assign bus.m_ctl_n      = '0;
  assign bus.m_dal_oe     = r.dal_oe;
  assign bus.m_ctl_oe     = r.ctl_oe;
  assign bus.iak_n        = r.iak_n;
  assign bus.dmg_n        = r.dmg_n;
  assign req_ready_o      = r.req_ready;
  assign rsp_valid_o      = r.rsp_valid;
  assign rsp_rdata_o      = r.rdata;
  assign rsp_timeout_o    = r.rsp_timeout;
  assign rsp_parity_err_o = r.rsp_par;
  assign irq_pending_o    = r.irq;
  assign dma_granted_o    = r.dma_granted;
  assign sys_halt_o       = r.halt;
  assign sys_event_o      = r.evnt;
  assign power_ok_o       = r.pok;
endmodule : bus_master_end

// >>> hdl/bus_slave_end.sv
`timescale 1ns/1ps
// memory slave with interrupt and dma request on the backplane
module bus_slave_end
  import bus_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 22'h000000,
  parameter int                MEM_WORDS = 256,
  parameter logic              IN_IO_PAGE = 1'b0,
  parameter int                REPLY_DLY = REPLY_CYC,
  parameter int                IRQ_LEVEL = 0,
  parameter logic [DATA_W-1:0] VECTOR    = 16'h0040
)(
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               int_req_i,
  input  wire logic               dma_req_i,
  output logic                    int_pending_o,
  output logic                    dma_owned_o,
  output logic                    wr_strobe_o,
  output logic                    int_ack_chain_out_n_o,
  output logic                    dma_grant_chain_out_n_o,
  backplane_if.slave              bus
);
  localparam int IW = $clog2(MEM_WORDS);

  if (MEM_WORDS < 2 || (1 << IW) != MEM_WORDS || IRQ_LEVEL >= IRQ_LVLS
      || REPLY_DLY < 1 || REPLY_DLY > MAX_REPLY_CYC)
  begin : g_bad_param
    $error("unsupported slave parameters");
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SEL  = 3'h1,
    S_DATA = 3'h2,
    S_HOLD = 3'h3,
    S_MISS = 3'h4
  } slv_state_type;

  typedef struct packed {
    slv_state_type     st;
    logic [ADDR_W-1:0] dal_oe;
    logic [CTL_W-1:0]  ctl_oe;
    logic              iak_out_n;
    logic              dmg_out_n;
    logic [IW-1:0]     idx;
    logic              lsb;
    logic              is_iack;
    logic              pending;
    logic              dma_owned;
    logic              wr_strobe;
    logic [DLY_W-1:0]  dly;
  } slv_reg_type;

  slv_reg_type               r;
  slv_reg_type               n;
  logic [DATA_W-1:0]         mem [MEM_WORDS];
  logic [ADDR_W+CTL_W+1:0]   in_n;
  logic [ADDR_W-1:0]         dal_a;
  logic [CTL_W-1:0]          ctl_a;
  logic                      iak_a;
  logic                      dmg_a;
  logic [ADDR_W-1:0]         offs;
  logic                      wr_en;

  sync_2ff #(
    .WIDTH     (ADDR_W + CTL_W + 2),
    .RESET_VAL ('1)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     ({bus.dmg_n, bus.iak_n, bus.ctl_n, bus.dal_n}),
    .q_o     (in_n)
  );
  assign dal_a = ~in_n[ADDR_W-1:0];
  assign ctl_a = ~in_n[ADDR_W+CTL_W-1:ADDR_W];
  assign iak_a = ~in_n[ADDR_W+CTL_W];
  assign dmg_a = ~in_n[ADDR_W+CTL_W+1];
  assign offs  = dal_a - BASE_ADDR;
  assign wr_en = (r.st == S_SEL) && ctl_a[LN_CYCLE] && ctl_a[LN_DOUT];

  // next-state logic of the slave
  always_comb
  begin
    n           = r;
    n.wr_strobe = 1'b0;
    n.pending   = r.pending | int_req_i;
    if (r.dly != '0)
    begin
      n.dly = r.dly - 1'b1;
    end
    case (r.st)
      S_IDLE:
      begin
        if (ctl_a[LN_CYCLE])
        begin
          // full 22-bit decode of the address phase
          n.idx = offs[IW:1];
          n.lsb = offs[0];
          if (dal_a >= BASE_ADDR && offs < ADDR_W'(2 * MEM_WORDS)
              && ctl_a[LN_IO_PAGE] == IN_IO_PAGE)
          begin
            n.st = S_SEL;
          end
          else
          begin
            n.st = S_MISS;
          end
        end
        else if (ctl_a[LN_DIN] && iak_a && r.pending)
        begin
          n.dal_oe  = ADDR_W'(VECTOR);
          n.is_iack = 1'b1;
          n.dly     = DLY_W'(REPLY_DLY - 1);
          n.st      = S_DATA;
        end
      end
      S_SEL:
      begin
        if (!ctl_a[LN_CYCLE])
        begin
          n.st = S_IDLE;
        end
        else if (ctl_a[LN_DIN])
        begin
          n.dal_oe = ADDR_W'(mem[r.idx]);
          n.dly    = DLY_W'(REPLY_DLY - 1);
          n.st     = S_DATA;
        end
        else if (ctl_a[LN_DOUT])
        begin
          n.wr_strobe = 1'b1;
          n.dly       = DLY_W'(REPLY_DLY - 1);
          n.st        = S_DATA;
        end
      end
      S_DATA:
      begin
        if (r.dly == '0)
        begin
          n.ctl_oe[LN_REPLY] = 1'b1;
          n.st               = S_HOLD;
        end
      end
      S_HOLD:
      begin
        // reply falls only after the strobe falls
        if (!ctl_a[LN_DIN] && !ctl_a[LN_DOUT])
        begin
          n.ctl_oe[LN_REPLY] = 1'b0;
          n.dal_oe           = '0;
          n.idx              = r.idx + 1'b1;
          n.st               = r.is_iack ? S_IDLE : S_SEL;
          if (r.is_iack)
          begin
            n.pending = int_req_i;
            n.is_iack = 1'b0;
          end
        end
      end
      S_MISS:
      begin
        if (!ctl_a[LN_CYCLE])
        begin
          n.st = S_IDLE;
        end
      end
      default:
      begin
        n.st = S_IDLE;
      end
    endcase
    // dma request and bus ownership
    if (r.dma_owned && !dma_req_i)
    begin
      n.dma_owned = 1'b0;
    end
    else if (!r.dma_owned && dma_req_i && dmg_a)
    begin
      n.dma_owned = 1'b1;
    end
    if (ctl_a[LN_INIT])
    begin
      n.st      = S_IDLE;
      n.dal_oe  = '0;
      n.is_iack = 1'b0;
      n.ctl_oe[LN_REPLY] = 1'b0;
    end
    n.ctl_oe[LN_DMA_REQ] = dma_req_i & ~n.dma_owned;
    n.ctl_oe[LN_DMA_ACK] = n.dma_owned;
    n.ctl_oe[LN_IRQ_BASE + IRQ_LEVEL] = n.pending;
    // chains pass on when this device is not asking
    n.iak_out_n = ~(iak_a & ~r.pending & (r.st == S_IDLE));
    n.dmg_out_n = ~(dmg_a & ~dma_req_i & ~r.dma_owned);
  end

  // word storage, byte lane picked by the low address bit
  always_ff @(posedge clk_i)
  begin
    if (wr_en && (!ctl_a[LN_WR_BYTE] || !r.lsb))
    begin
      mem[r.idx][7:0] <= dal_a[7:0];
    end
    if (wr_en && (!ctl_a[LN_WR_BYTE] || r.lsb))
    begin
      mem[r.idx][15:8] <= dal_a[15:8];
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      r           <= '0;
      r.iak_out_n <= 1'b1;
      r.dmg_out_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // open-collector drive
  assign bus.s_dal_n              = '0;
  assign bus.s_ctl_n              = '0;
  assign bus.s_dal_oe             = r.dal_oe;
  assign bus.s_ctl_oe             = r.ctl_oe;
  assign int_pending_o            = r.pending;
  assign dma_owned_o              = r.dma_owned;
  assign wr_strobe_o              = r.wr_strobe;
  assign int_ack_chain_out_n_o    = r.iak_out_n;
  assign dma_grant_chain_out_n_o  = r.dmg_out_n;
endmodule : bus_slave_end

// >>> tb/bus_assertions.sv
`timescale 1ns/1ps
// handshake checker on the shared backplane lines
module bus_assertions
  import bus_pkg::*;
#(
  parameter int TO = 100
)(
  input wire logic             clk_i,
  input wire logic             reset_i,
  input wire logic [CTL_W-1:0] ctl_n,
  input wire logic [ADDR_W-1:0] m_dal_oe,
  input wire logic [CTL_W-1:0] m_ctl_oe,
  input wire logic [CTL_W-1:0] s_ctl_oe,
  input wire logic             iak_n,
  input wire logic             dmg_n
);
  logic        strobe;
  logic [15:0] strobe_cnt_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // master data strobe, either direction
  assign strobe = m_ctl_oe[LN_DIN] | m_ctl_oe[LN_DOUT];

  // length of the current strobe
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      strobe_cnt_r <= '0;
    else
      strobe_cnt_r <= strobe ? strobe_cnt_r + 16'h1 : '0;
  end

  chk_reply_slave_only: assert property (
    !ctl_n[LN_REPLY] |-> s_ctl_oe[LN_REPLY]) else $error("stray reply");
  chk_single_master: assert property (
    !(s_ctl_oe[LN_CYCLE] | s_ctl_oe[LN_DIN] | s_ctl_oe[LN_DOUT]))
    else $error("slave drove transfer line");
  chk_cycle_spans: assert property (
    m_ctl_oe[LN_DOUT] |-> m_ctl_oe[LN_CYCLE]) else $error("dout no cycle");
  chk_reply_needs_strobe: assert property (
    $rose(s_ctl_oe[LN_REPLY]) |-> !ctl_n[LN_DIN] || !ctl_n[LN_DOUT])
    else $error("reply without strobe");
  chk_strobe_waits: assert property (
    $rose(s_ctl_oe[LN_REPLY]) |-> strobe[*2]) else $error("strobe too short");
  chk_abort_bound: assert property (
    strobe_cnt_r <= TO) else $error("cycle not aborted");
  chk_addr_setup: assert property (
    $rose(m_ctl_oe[LN_CYCLE]) |-> $past(m_dal_oe, 3) == m_dal_oe)
    else $error("address not set up");
  chk_ack_head: assert property (
    $fell(iak_n) |-> m_ctl_oe[LN_DIN]) else $error("ack without din");
  chk_grant_on_req: assert property (
    $fell(dmg_n) |-> !ctl_n[LN_DMA_REQ]) else $error("grant unrequested");
endmodule : bus_assertions

// >>> tb/tb.sv
`timescale 1ns/1ps
// processor end and memory end joined on one backplane
module tb;
  import bus_pkg::*;
  localparam int          TO  = 100;
  localparam [DATA_W-1:0] VEC = 16'h00a4;
  logic                clk = 1'h0, rst = 1'h1;
  logic                vld = 1'h0, wr = 1'h0, byt = 1'h0, io = 1'h0;
  logic                more = 1'h0, iack = 1'h0, ireq = 1'h0, dreq = 1'h0;
  logic [ADDR_W-1:0]   addr = '0;
  logic [DATA_W-1:0]   wdat = '0, rdat;
  logic                rdy, rv, rto, perr, dgr, ipend, down, iko_n, tmo;
  logic                hlt, evt, pok, ini = 1'h0, wrs, dgo_n;
  logic [15:0]         wr_cnt = '0;
  logic [IRQ_LVLS-1:0] irqp;
  logic [DATA_W-1:0]   wd [5];
  logic [DATA_W-1:0]   rd [4];
  int                  num_errors = 0, num_checks = 0;

  backplane_if bp ();
  bus_master_end #(.TIMEOUT_CYC(TO), .SLOWEST_CYC(20)) bus_master_end_i (
    .clk_i(clk), .reset_i(rst), .req_valid_i(vld), .req_write_i(wr),
    .req_byte_i(byt), .req_io_i(io), .req_more_i(more), .req_addr_i(addr),
    .req_wdata_i(wdat), .iack_req_i(iack), .init_req_i(ini),
    .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_rdata_o(rdat),
    .rsp_timeout_o(rto), .rsp_parity_err_o(perr), .irq_pending_o(irqp),
    .dma_granted_o(dgr), .sys_halt_o(hlt), .sys_event_o(evt),
    .power_ok_o(pok),
    .bus(bp));
  bus_slave_end #(.VECTOR(VEC)) bus_slave_end_i (.clk_i(clk), .reset_i(rst),
    .int_req_i(ireq), .dma_req_i(dreq), .int_pending_o(ipend),
    .dma_owned_o(down), .wr_strobe_o(wrs), .int_ack_chain_out_n_o(iko_n),
    .dma_grant_chain_out_n_o(dgo_n), .bus(bp));
  bus_assertions #(.TO(TO)) bus_assertions_i (.clk_i(clk), .reset_i(rst),
    .ctl_n(bp.ctl_n), .m_dal_oe(bp.m_dal_oe), .m_ctl_oe(bp.m_ctl_oe),
    .s_ctl_oe(bp.s_ctl_oe), .iak_n(bp.iak_n), .dmg_n(bp.dmg_n));

  // free-running module clock
  initial
  begin
    forever #2 clk = ~clk;
  end

  // count words the slave reports as written
  always @(posedge clk)
  begin
    if (wrs === 1'h1)
      wr_cnt <= wr_cnt + 16'h1;
  end

  // compare one result and count it
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // one request of n words from wd, read words to rd; ia for vector fetch
  task automatic xfer(input logic w, b, s, ia, input logic [ADDR_W-1:0] a,
                      input int n);
    int i;
    int t;
    i = 0;
    t = 0;
    while (rdy !== 1'h1)
      @(posedge clk);
    wr <= w;
    byt <= b;
    io <= s;
    addr <= a;
    wdat <= wd[0];
    vld <= !ia;
    iack <= ia;
    @(posedge clk);
    vld <= 1'h0;
    iack <= 1'h0;
    wdat <= wd[1];
    more <= (n > 1);
    while (i < n && t < 500)
    begin
      @(posedge clk);
      t++;
      tmo = (rto === 1'h1);
      if (tmo)
        i = n;
      else if (rv === 1'h1)
      begin
        rd[i] = rdat;
        i++;
        wdat <= wd[(i + 1) % 5];
        more <= (i + 1 < n);
      end
    end
    chk({15'h0, (t < 500)}, 16'h0001);
  endtask : xfer

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    wd = '{16'ha5c3, 16'h1111, 16'h2222, 16'h3333, 16'h0000};
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 22'h000010, 1);
    chk({15'h0, tmo}, 16'h0000);
    xfer(1'h1, 1'h0, 1'h0, 1'h0, 22'h000040, 4);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 22'h000042, 3);
    for (int k = 0; k < 3; k++) chk(rd[k], wd[k + 1]);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 22'h000010, 1);
    chk(rd[0], 16'ha5c3);
    chk({15'h0, perr}, 16'h0000);
    wd[0] = 16'hbe00;
    xfer(1'h1, 1'h1, 1'h0, 1'h0, 22'h000011, 1);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 22'h000010, 1);
    chk(rd[0], 16'hbec3);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 22'h200010, 1);
    chk({15'h0, tmo}, 16'h0001);
    xfer(1'h0, 1'h0, 1'h1, 1'h0, 22'h000010, 1);
    chk({15'h0, tmo}, 16'h0001);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 22'h010010, 1);
    chk({15'h0, tmo}, 16'h0001);
    ireq <= 1'h1;
    @(posedge clk);
    ireq <= 1'h0;
    for (int k = 0; k < 20 && irqp[0] !== 1'h1; k++) @(posedge clk);
    chk({12'h0, irqp}, 16'h0001);
    xfer(1'h0, 1'h0, 1'h0, 1'h1, 22'h000000, 1);
    chk(rd[0], VEC);
    for (int k = 0; k < 20 && ipend !== 1'h0; k++) @(posedge clk);
    chk({14'h0, ipend, iko_n}, 16'h0001);
    dreq <= 1'h1;
    for (int k = 0; k < 50 && dgr !== 1'h1; k++) @(posedge clk);
    chk({13'h0, dgr, down, dgo_n}, 16'h0007);
    dreq <= 1'h0;
    for (int k = 0; k < 50 && dgr !== 1'h0; k++) @(posedge clk);
    chk({14'h0, dgr, down}, 16'h0000);
    ini <= 1'h1;
    @(posedge clk);
    ini <= 1'h0;
    repeat (2) @(posedge clk);
    chk({15'h0, rdy}, 16'h0000);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 22'h000044, 1);
    chk(rd[0], 16'h2222);
    chk(wr_cnt, 16'h0006);
    chk({13'h0, hlt, evt, pok}, 16'h0000);
    print_verdict();
  end

  // cut a hang short far past the thousand or so cycles expected
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : tb
